//--- inc/mpfm_map.vh
/*
 Register offsets, field positions, reset values and timing figures for the
 maintenance power fail monitor. Assumes a 100 MHz clock and a 32-bit
 classic Wishbone register bus with byte addresses.
*/
`ifndef MPFM_MAP_VH
`define MPFM_MAP_VH

// ==========================================================
// clock and timing
`define MPFM_CLK_KHZ          100000
`define MPFM_STRETCH_MS       150
`define MPFM_RESTORE_MS       100
`define MPFM_UPDATE_MS        220
`define MPFM_STRETCH_CYC      (`MPFM_STRETCH_MS * `MPFM_CLK_KHZ)
`define MPFM_RESTORE_CYC      (`MPFM_RESTORE_MS * `MPFM_CLK_KHZ)
`define MPFM_UPDATE_CYC       (`MPFM_UPDATE_MS * `MPFM_CLK_KHZ)
`define MPFM_CNT_W            25

// ==========================================================
// time-slot word bit positions of the interrogation code
`define MPFM_SLOT_W           16
`define MPFM_SLOT_RING_HI     15
`define MPFM_SLOT_RING_LO     14
`define MPFM_SLOT_MAINT       11

// ==========================================================
// registers
`define MPFM_ADDR_W           4
`define MPFM_REG_CTRL         4'h0
`define MPFM_REG_STATUS       4'h4
`define MPFM_CTRL_RESERVE     0
`define MPFM_CTRL_RESET       1'h0

// status field positions
`define MPFM_ST_PF_A          0
`define MPFM_ST_PF_B          1
`define MPFM_ST_LATCH_A       2
`define MPFM_ST_LATCH_B       3
`define MPFM_ST_RELAY_A       4
`define MPFM_ST_RELAY_B       5
`define MPFM_ST_UPDATE        6
`define MPFM_ST_SP265         7
`define MPFM_ST_SP266         8
`define MPFM_ST_PATH_A        9
`define MPFM_ST_PATH_B        10
`define MPFM_ST_RESERVE       11
`define MPFM_ST_CKI_LO        12

`endif

//--- hdl/mpfm_top.v
/*
 Maintenance power fail monitor: interrogation code decode, multiple
 closure detector onto scan point 265, fuse alarm onto scan point 266,
 duplicated ac failure detection with minimum-width stretching, clock
 inhibits, power failure relays, restore clock stoppage, scanner update
 interval and emergency line transfer, plus a classic Wishbone slave.
 Assumes one 100 MHz clock; monitor, fuse and ac detector inputs are pins
 from outside the clock domain; the time-slot word comes from same-clock
 logic.
*/
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "mpfm_map.vh"

// ==========================================================
// two flip-flop synchroniser
module mpfm_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {W{1'b0}};
			q      <= {W{1'b0}};
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// ==========================================================
// level follower with a guaranteed minimum active width; with a one-cycle
// trigger on its input it acts as a fixed-length one-shot
module mpfm_hold #(
	parameter             CNT_W = `MPFM_CNT_W,
	parameter [CNT_W-1:0] CYC   = 1
) (
	input  wire clk,
	input  wire rst_n,
	input  wire in,
	output reg  out_q
);
	reg             prev_q;
	reg [CNT_W-1:0] cnt_q;
	wire            rise = in & ~prev_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
			cnt_q  <= {CNT_W{1'b0}};
			out_q  <= 1'b0;
		end else begin
			prev_q <= in;
			if (rise)
				cnt_q <= CYC - {{(CNT_W-1){1'b0}}, 1'b1};
			else if (cnt_q != {CNT_W{1'b0}})
				cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
			// output tracks the input level, never shorter than CYC cycles
			// counting down to zero keeps the output up for the full CYC cycles
			out_q <= in | rise | (cnt_q != {CNT_W{1'b0}});
		end
	end
endmodule

// ==========================================================
// Summary of operation
// - slot word bits 11,14,15 form interrogation code
// - code 0,1,1 raises first detector enable
// - code 1,0,0 raises second detector enable
// - both ring bits set suppress ring outputs
// - sixteen group, four special, four intergroup monitors
// - gated monitors ORed onto scan point 265
// - scan point 265 idle without detector enable
// - fuse alarm drives scan point 266 off-hook
// - both ac detectors must agree
// - stretched output follows input, minimum 150 ms
// - failure latch follows stretched detector level
// - power fail only when both latches set
// - power fail raises all clock inhibits
// - non-reserve units release both relays on failure
// - restored ac clears latches, signals and inhibit
// - relay re-operate gives 100 ms inhibit pulse
// - reserve units keep relays, still stop clock
// - released relays transfer six station lines
// - released relays short digit trunk 3
// - transfer trigger starts 220 ms update interval
module mpfm_top #(
	parameter STRETCH_CYC = `MPFM_STRETCH_CYC,
	parameter RESTORE_CYC = `MPFM_RESTORE_CYC,
	parameter UPDATE_CYC  = `MPFM_UPDATE_CYC
) (
	input  wire                      clk,
	input  wire                      rst_n,
	input  wire                      wb_cyc_i,
	input  wire                      wb_stb_i,
	input  wire                      wb_we_i,
	input  wire [`MPFM_ADDR_W-1:0]   wb_adr_i,
	input  wire [3:0]                wb_sel_i,
	input  wire [31:0]               wb_dat_i,
	output reg  [31:0]               wb_dat_o,
	output reg                       wb_ack_o,
	input  wire [`MPFM_SLOT_W-1:0]   slot_word,
	input  wire                      slot_load,
	input  wire [15:0]               group_closure_monitor,
	input  wire [3:0]                special_group_closure_monitor,
	input  wire [3:0]                intergroup_closure_monitor,
	input  wire                      fuse_alarm,
	input  wire                      ac_detector_out_a,
	input  wire                      ac_detector_out_b,
	output reg                       detector_enable_path_a,
	output reg                       detector_enable_path_b,
	output reg                       ring_out,
	output reg                       ringback_out,
	output reg                       scan_point_265,
	output reg                       scan_point_266,
	output reg                       power_fail_signal_a,
	output reg                       power_fail_signal_b,
	output reg  [3:0]                clock_inhibit_out,
	output reg                       power_fail_relay_a,
	output reg                       power_fail_relay_b,
	output reg                       power_restore_pulse,
	output reg                       scanner_update_interval,
	output reg  [5:0]                station_line_transfer_relay,
	output reg                       digit_trunk3_short
);
	// ==========================================================
	// pin synchronisers
	wire [15:0] grp_s;
	wire [3:0]  spg_s;
	wire [3:0]  igs_s;
	wire        fuse_s;
	wire        ac_a_s;
	wire        ac_b_s;

	mpfm_sync #(.W(27)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({group_closure_monitor, special_group_closure_monitor,
		         intergroup_closure_monitor, fuse_alarm,
		         ac_detector_out_a, ac_detector_out_b}),
		.q     ({grp_s, spg_s, igs_s, fuse_s, ac_a_s, ac_b_s})
	);

	// ==========================================================
	// registers
	reg  reserve_q;
	reg  maint_bit_q;
	reg  ring_lo_q;
	reg  ring_hi_q;
	reg  latch_a_q;
	reg  latch_b_q;
	reg  relay_prev_q;
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reserve_q <= `MPFM_CTRL_RESET;
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0000_0000;
		end else begin
			// one wait state; the ack drops the cycle after it is given
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && wb_we_i && wb_adr_i == `MPFM_REG_CTRL && wb_sel_i[0])
				reserve_q <= wb_dat_i[`MPFM_CTRL_RESERVE];
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
				`MPFM_REG_CTRL: begin
					wb_dat_o[`MPFM_CTRL_RESERVE] <= reserve_q;
				end
				`MPFM_REG_STATUS: begin
					wb_dat_o[`MPFM_ST_PF_A]    <= power_fail_signal_a;
					wb_dat_o[`MPFM_ST_PF_B]    <= power_fail_signal_b;
					wb_dat_o[`MPFM_ST_LATCH_A] <= latch_a_q;
					wb_dat_o[`MPFM_ST_LATCH_B] <= latch_b_q;
					wb_dat_o[`MPFM_ST_RELAY_A] <= power_fail_relay_a;
					wb_dat_o[`MPFM_ST_RELAY_B] <= power_fail_relay_b;
					wb_dat_o[`MPFM_ST_UPDATE]  <= scanner_update_interval;
					wb_dat_o[`MPFM_ST_SP265]   <= scan_point_265;
					wb_dat_o[`MPFM_ST_SP266]   <= scan_point_266;
					wb_dat_o[`MPFM_ST_PATH_A]  <= detector_enable_path_a;
					wb_dat_o[`MPFM_ST_PATH_B]  <= detector_enable_path_b;
					wb_dat_o[`MPFM_ST_RESERVE] <= reserve_q;
					wb_dat_o[`MPFM_ST_CKI_LO+3:`MPFM_ST_CKI_LO] <= clock_inhibit_out;
				end
				default: begin
					// unmapped offsets are acknowledged and read as zero
					wb_dat_o <= 32'h0000_0000;
				end
				endcase
			end
		end
	end

	// ==========================================================
	// interrogation code and multiple closure detector
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			maint_bit_q            <= 1'b0;
			ring_lo_q              <= 1'b0;
			ring_hi_q              <= 1'b0;
			detector_enable_path_a <= 1'b0;
			detector_enable_path_b <= 1'b0;
			ring_out               <= 1'b0;
			ringback_out           <= 1'b0;
			scan_point_265         <= 1'b0;
			scan_point_266         <= 1'b0;
		end else begin
			if (slot_load) begin
				ring_hi_q   <= slot_word[`MPFM_SLOT_RING_HI];
				ring_lo_q   <= slot_word[`MPFM_SLOT_RING_LO];
				maint_bit_q <= slot_word[`MPFM_SLOT_MAINT];
			end
			detector_enable_path_a <= ~maint_bit_q & ring_lo_q & ring_hi_q;
			detector_enable_path_b <= maint_bit_q & ~ring_lo_q & ~ring_hi_q;
			// the all-ones ring pair is reserved as an interrogation code
			ring_out     <= ring_hi_q & ~ring_lo_q;
			ringback_out <= ring_lo_q & ~ring_hi_q;
			// closures during ordinary talking slots stay invisible
			scan_point_265 <= (detector_enable_path_a & (|grp_s | |spg_s))
			                | (detector_enable_path_b & |igs_s);
			// scanner on the far side reports the transition
			scan_point_266 <= fuse_s;
		end
	end

	// ==========================================================
	// ac failure detection
	wire str_a;
	wire str_b;
	wire restore_hold;
	wire update_hold;

	mpfm_hold #(.CYC(STRETCH_CYC[`MPFM_CNT_W-1:0])) u_stretch_a (
		.clk   (clk),
		.rst_n (rst_n),
		.in    (ac_a_s),
		.out_q (str_a)
	);

	mpfm_hold #(.CYC(STRETCH_CYC[`MPFM_CNT_W-1:0])) u_stretch_b (
		.clk   (clk),
		.rst_n (rst_n),
		.in    (ac_b_s),
		.out_q (str_b)
	);

	// restore stoppage and scanner update one-shots
	mpfm_hold #(.CYC(RESTORE_CYC[`MPFM_CNT_W-1:0])) u_restore (
		.clk   (clk),
		.rst_n (rst_n),
		.in    (power_restore_pulse),
		.out_q (restore_hold)
	);

	wire pf_rise = latch_a_q & latch_b_q & ~power_fail_signal_a;
	wire pf_fall = ~(latch_a_q & latch_b_q) & power_fail_signal_a;
	wire relays_up = power_fail_relay_a & power_fail_relay_b;

	// failure onset and restore both count as transfers
	mpfm_hold #(.CYC(UPDATE_CYC[`MPFM_CNT_W-1:0])) u_update (
		.clk   (clk),
		.rst_n (rst_n),
		.in    (pf_rise | power_restore_pulse),
		.out_q (update_hold)
	);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_a_q                   <= 1'b0;
			latch_b_q                   <= 1'b0;
			power_fail_signal_a         <= 1'b0;
			power_fail_signal_b         <= 1'b0;
			power_fail_relay_a          <= 1'b1;
			power_fail_relay_b          <= 1'b1;
			relay_prev_q                <= 1'b1;
			power_restore_pulse         <= 1'b0;
			clock_inhibit_out           <= 4'h0;
			scanner_update_interval     <= 1'b0;
			station_line_transfer_relay <= 6'h00;
			digit_trunk3_short          <= 1'b0;
		end else begin
			// reset whenever the stretched level is idle, set while active
			latch_a_q <= str_a;
			latch_b_q <= str_b;
			// a single faulty detector cannot raise power fail
			power_fail_signal_a <= latch_a_q & latch_b_q;
			power_fail_signal_b <= latch_a_q & latch_b_q;
			// reserve units keep the relays up through every failure
			power_fail_relay_a <= ~(power_fail_signal_a & ~reserve_q);
			power_fail_relay_b <= ~(power_fail_signal_b & ~reserve_q);
			relay_prev_q <= relays_up;
			// relay re-operate, or restore to normal supply on reserve units
			power_restore_pulse <= (relays_up & ~relay_prev_q)
			                     | (reserve_q & pf_fall);
			// counters stay frozen only while both failure latches are set, not through the restore pulse
			clock_inhibit_out[3:2] <= {2{latch_a_q & latch_b_q}};
			// power fail and released relays bridge the gap before the restore pulse
			clock_inhibit_out[1:0] <= {2{(latch_a_q & latch_b_q) | power_fail_signal_a
			                          | ~relays_up | (relays_up & ~relay_prev_q)
			                          | restore_hold | power_restore_pulse}};
			scanner_update_interval <= update_hold;
			// emergency service while both relays are released
			station_line_transfer_relay <= {6{~power_fail_relay_a & ~power_fail_relay_b}};
			digit_trunk3_short <= ~power_fail_relay_a & ~power_fail_relay_b;
		end
	end
endmodule

//--- tb/mpfm_chk_sva.sv
/*
 Port-level checks for the maintenance power fail monitor.
 Assumes the restore one-shot lasts at least seven cycles and the stretch at least eight.
*/
`timescale 1ns/1ps

// ==========================================================
// checker
module mpfm_chk (
	input wire       clk,
	input wire       rst_n,
	input wire       detector_enable_path_a,
	input wire       detector_enable_path_b,
	input wire       scan_point_265,
	input wire       power_fail_signal_a,
	input wire       power_fail_signal_b,
	input wire [3:0] clock_inhibit_out,
	input wire       power_fail_relay_a,
	input wire       power_fail_relay_b,
	input wire       power_restore_pulse,
	input wire [5:0] station_line_transfer_relay,
	input wire       digit_trunk3_short
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_released;
		!power_fail_relay_a && !power_fail_relay_b;
	endsequence
	sequence s_hold;
		(clock_inhibit_out[1:0] == 2'h3) [*8];
	endsequence
	paths_excl_a: assert property (!(detector_enable_path_a && detector_enable_path_b))
		else $error("both detector enables high");
	sp265_gate_a: assert property (!detector_enable_path_a && !detector_enable_path_b |=> !scan_point_265)
		else $error("scan point 265 off-hook without enable");
	pf_pair_a: assert property (power_fail_signal_a == power_fail_signal_b)
		else $error("power fail signals disagree");
	pf_inhibit_a: assert property (power_fail_signal_a |-> clock_inhibit_out == 4'hf)
		else $error("clock inhibit missing during power fail");
	line_transfer_a: assert property (s_released |=> station_line_transfer_relay == 6'h3f && digit_trunk3_short)
		else $error("released relays gave no transfer");
	stretch_min_a: assert property ($rose(power_fail_signal_a) |-> power_fail_signal_a [*8])
		else $error("power fail shorter than minimum");
	restore_pulse_a: assert property ($fell(power_fail_signal_a) |-> ##[0:4] power_restore_pulse)
		else $error("no restore pulse after power fail");
	restore_hold_a: assert property (power_restore_pulse |=> s_hold)
		else $error("restore inhibit too short");
endmodule

bind mpfm_top mpfm_chk u_chk (.clk(clk), .rst_n(rst_n),
	.detector_enable_path_a(detector_enable_path_a), .detector_enable_path_b(detector_enable_path_b),
	.scan_point_265(scan_point_265), .power_fail_signal_a(power_fail_signal_a),
	.power_fail_signal_b(power_fail_signal_b), .clock_inhibit_out(clock_inhibit_out),
	.power_fail_relay_a(power_fail_relay_a), .power_fail_relay_b(power_fail_relay_b),
	.power_restore_pulse(power_restore_pulse), .digit_trunk3_short(digit_trunk3_short),
	.station_line_transfer_relay(station_line_transfer_relay));

//--- tb/mpfm_scanner.sv
/*
 Far-side scanner model: counts fuse-failure messages from scan point 266.
 Assumes scan points are same-clock levels, high meaning off-hook.
*/
`timescale 1ns/1ps

// ==========================================================
// scanner
module mpfm_scanner (
	input wire       clk,
	input wire       rst_n,
	input wire       scan_point_266,
	input wire       scanner_update_interval,
	output reg [7:0] fuse_msg_q
);
	reg last_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_q <= 1'b0;
			fuse_msg_q <= 8'h00;
		end else begin
			last_q <= scan_point_266;
			// messages dropped, not counted later, while the last-look memory refreshes
			if (scan_point_266 && !last_q && !scanner_update_interval)
				fuse_msg_q <= fuse_msg_q + 8'h01;
		end
	end
endmodule

//--- tb/test_maint_power_fail_monitor.sv
/*
 Self-checking bench for the maintenance power fail monitor.
 Assumes shortened stretch, restore and update counts.
*/
`timescale 1ns/1ps

// ==========================================================
// bench
module test_maint_power_fail_monitor;
	localparam S = 20, R = 10, U = 30;
	reg clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, load = 0, fuse = 0, ac_a = 0, ac_b = 0;
	reg [3:0] adr = 4'h0, sgm = 4'h0, igm = 4'h0;
	reg [31:0] wdat = 32'h0, rd;
	reg [15:0] slot = 16'h0, grp = 16'h0;
	wire [31:0] dat_o;
	wire ack, pa, pb, rg, rb, sp5, sp6, pfa, pfb, rla, rlb, rp, upd, dt3;
	wire [3:0] cki;
	wire [5:0] slt;
	wire [7:0] fmsg;
	integer err_total = 0, n_tests = 0, tick = 0;
	always #5 clk = ~clk;
	mpfm_top #(.STRETCH_CYC(S), .RESTORE_CYC(R), .UPDATE_CYC(U)) uut (.clk(clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .slot_word(slot), .slot_load(load),
		.group_closure_monitor(grp), .special_group_closure_monitor(sgm),
		.intergroup_closure_monitor(igm), .fuse_alarm(fuse), .ac_detector_out_a(ac_a),
		.ac_detector_out_b(ac_b), .detector_enable_path_a(pa), .detector_enable_path_b(pb),
		.ring_out(rg), .ringback_out(rb), .scan_point_265(sp5), .scan_point_266(sp6),
		.power_fail_signal_a(pfa), .power_fail_signal_b(pfb), .clock_inhibit_out(cki),
		.power_fail_relay_a(rla), .power_fail_relay_b(rlb), .power_restore_pulse(rp),
		.scanner_update_interval(upd), .station_line_transfer_relay(slt),
		.digit_trunk3_short(dt3));
	mpfm_scanner u_scan (.clk(clk), .rst_n(rst_n), .scan_point_266(sp6),
		.scanner_update_interval(upd), .fuse_msg_q(fmsg));
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task summarize;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		tick <= tick + 1;
		if (tick == 20000) begin
			err_total++;
			summarize;
		end
	end
	task nwait(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task t_regs;
		check({rla, rlb, pfa, cki, slt}, {2'b11, 11'h0}, "reset outs");
		wb(0, 4'h4, 0);
		check(rd, 32'h30, "status");
		wb(1, 4'h8, 32'hffffffff);
		wb(0, 4'h8, 0);
		check(rd, 0, "unmapped");
	endtask
	task t_decode;
		integer c, m;
		logic ea, eb;
		for (c = 0; c < 8; c++) begin
			@(posedge clk);
			slot <= {c[2], c[1], 2'b00, c[0], 11'h000};
			load <= 1;
			@(posedge clk);
			load <= 0;
			ea = (c == 6);
			eb = (c == 1);
			nwait(2);
			check(pa, ea, "path a");
			check(pb, eb, "path b");
			check({rg, rb}, {c[2] & ~c[1], c[1] & ~c[2]}, "ring");
			for (m = 0; m < 3; m++) begin
				@(posedge clk);
				grp <= (m == 0) ? 16'h1 << (2 * c + 1) : 16'h0;
				sgm <= (m == 1) ? 4'h1 << c[1:0] : 4'h0;
				igm <= (m == 2) ? 4'h1 << c[1:0] : 4'h0;
				nwait(5);
				check(sp5, (m < 2) ? ea : eb, "sp265");
			end
		end
		@(posedge clk);
		grp <= 0; sgm <= 0; igm <= 0;
	endtask
	task t_fuse;
		@(posedge clk);
		fuse <= 1;
		nwait(5);
		check({sp6, fmsg}, {1'b1, 8'h01}, "fuse");
		@(posedge clk);
		fuse <= 0;
		nwait(5);
		check(sp6, 0, "fuse off");
	endtask
	task t_single;
		integer i;
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			ac_a <= (i == 0); ac_b <= (i == 1);
			nwait(40);
			check({pfa, pfb, rla, rlb}, 4'b0011, "one detector");
			@(posedge clk);
			ac_a <= 0; ac_b <= 0;
			nwait(S + 10);
		end
	endtask
	task t_fail(input logic rsv, input integer dur);
		integer w, k, gap;
		wb(1, 4'h0, {31'h0, rsv});
		gap = 0;
		fork
			begin
				@(posedge clk);
				ac_a <= 1; ac_b <= 1;
				repeat (dur) @(posedge clk);
				ac_a <= 0; ac_b <= 0;
			end
			begin
				k = 0;
				while (pfa !== 1'b1 && k < 50) begin @(negedge clk); k++; end
				nwait(2);
				check(cki, 4'hf, "inhibit");
				check({rla, rlb}, {2{rsv}}, "relays");
				check({slt, dt3, upd}, rsv ? 8'h01 : 8'hff, "transfer");
				w = 2;
				while (pfa === 1'b1 && w < 500) begin
					if (cki[1:0] !== 2'b11) gap++;
					@(negedge clk); w++;
				end
			end
		join
		check(w >= (dur > S ? dur : S), 1, "pf width");
		k = 0;
		while (rp !== 1'b1 && k < 20) begin
			if (cki[1:0] !== 2'b11) gap++;
			@(negedge clk); k++;
		end
		check({rp, pfb, cki[3:2]}, 4'b1000, "restore");
		nwait(1);
		w = 0;
		while (cki[1:0] === 2'b11 && w < 100) begin @(negedge clk); w++; end
		check(w >= R && w <= R + 2, 1, "restore hold");
		check({gap, rla, rlb}, {32'h0, 2'b11}, "inhibit gap");
		nwait(U + 10);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		t_regs;
		t_decode;
		t_fuse;
		t_single;
		t_fail(0, 2);
		t_fail(0, 40);
		t_fail(1, 2);
		summarize;
	end
endmodule
